// ===== verilog/rimc_consts.vh
`ifndef RIMC_CONSTS_VH
`define RIMC_CONSTS_VH

// ----------------------------------------------------------------------
// register indices within one port (byte address = 4 * index)
// ----------------------------------------------------------------------
`define RIMC_IDX_MASK2       8'ha1
`define RIMC_IDX_MASK3       8'ha2
`define RIMC_IDX_MASK4       8'ha3
`define RIMC_IDX_MASK5       8'ha4
`define RIMC_IDX_MASK7       8'ha6
`define RIMC_IDX_SCE1        8'ha8
`define RIMC_IDX_SCE2        8'ha9
`define RIMC_IDX_SCE3        8'haa
`define RIMC_IDX_SCE4        8'hab
`define RIMC_IDX_LUP1        8'hac
`define RIMC_IDX_LUP2        8'had
`define RIMC_IDX_CTRL        8'hf0
`define RIMC_IDX_STAT        8'hf1
// port stride 200h in index units: index bits [11:9] select the port
`define RIMC_PORT_STRIDE     12'h200

// ----------------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------------
`define RIMC_RST_VAL         8'h00
`define RIMC_M2_BITS         8'h0f
`define RIMC_M3_E1_BITS      8'hbb
`define RIMC_M4_BITS         8'hef
`define RIMC_M5_BITS         8'h3f
`define RIMC_M7_T1_BITS      8'h3f
`define RIMC_M7_E1_BITS      8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RIMC_SCOS_BIT        3
`define RIMC_CTRL_E1_BIT     0
`define RIMC_CTRL_LEN_HI     7
`define RIMC_CTRL_LEN_LO     4
`define RIMC_STAT_SCOS_BIT   0
`define RIMC_STAT_LUP_BIT    1
`define RIMC_STAT_INT_BIT    2
`define RIMC_SUM_RLS2        1
`define RIMC_SUM_RLS3        2
`define RIMC_SUM_RLS4        3
`define RIMC_SUM_RLS5        4
`define RIMC_SUM_RLS7        6

// ----------------------------------------------------------------------
// timing: loop-up integration in received bits
// ----------------------------------------------------------------------
`define RIMC_LUP_INTEG       16'd48

`endif

// ===== verilog/rimc_rx_int_mask.v
`timescale 1ns/10ps
`default_nettype none
`include "rimc_consts.vh"

module rimc_rx_int_mask #(
    parameter        PORTS    = 8,
    parameter        CHANNELS = 32,
    parameter [15:0] LUP_INTEG = `RIMC_LUP_INTEG
) (
    input  wire                   clock,
    input  wire                   rst_n,
    input  wire                   hsel,
    input  wire [31:0]            haddr,
    input  wire [1:0]             htrans,
    input  wire                   hwrite,
    input  wire [2:0]             hsize,
    input  wire [31:0]            hwdata,
    input  wire                   hready,
    output reg  [31:0]            hrdata,
    output reg                    hreadyout,
    output reg                    hresp,
    input  wire [PORTS*8-1:0]     latchedStatus2,
    input  wire [PORTS*8-1:0]     latchedStatus3,
    input  wire [PORTS*8-1:0]     latchedStatus4,
    input  wire [PORTS*8-1:0]     latchedStatus5,
    input  wire [PORTS*8-1:0]     latchedStatus7,
    input  wire [PORTS*CHANNELS-1:0] sigChange,
    input  wire [PORTS-1:0]       rxData,
    input  wire [PORTS-1:0]       rxDataValid,
    output wire [PORTS-1:0]       loopUpDet,
    output wire [PORTS*8-1:0]     rxIntSummary,
    output reg                    interruptOutN
);

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    reg         wrPend_q;
    reg         rdPend_q;
    reg         addrHit_q;
    reg  [11:0] addrIdx_q;
    wire [7:0]  regIdx  = addrIdx_q[7:0];
    wire [2:0]  portIdx = addrIdx_q[11:9];
    wire [PORTS*8-1:0] portRd;
    wire [PORTS-1:0]   portReq;
    wire        accept  = hsel & hready & htrans[1];

    // address phase captured; reads take one wait state so that a write
    // in the previous data phase is always visible, no forwarding needed
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q  <= 1'b0;
            rdPend_q  <= 1'b0;
            addrHit_q <= 1'b0;
            addrIdx_q <= 12'h000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_q <= 1'b0;
            hresp    <= 1'b0;  // always OKAY, unmapped reads give zero
            if (rdPend_q) begin
                rdPend_q  <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= addrHit_q ?
                    {24'h00_0000, portRd[portIdx*8 +: 8]} : 32'h0000_0000;
            end else if (accept) begin
                addrIdx_q <= haddr[13:2];
                addrHit_q <= (haddr[31:14] == 18'h0_0000) & ~haddr[10]
                             & (haddr[1:0] == 2'b00);
                if (hwrite) begin
                    wrPend_q <= 1'b1;
                end else begin
                    rdPend_q  <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // per-port register bank, change latch and loop-up detector
    // ------------------------------------------------------------------
    genvar p;
    genvar c;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : gPort
            reg  [7:0]  mask2_q;
            reg  [7:0]  mask3_q;
            reg  [7:0]  mask4_q;
            reg  [7:0]  mask5_q;
            reg  [7:0]  mask7_q;
            reg  [7:0]  sce1_q;
            reg  [7:0]  sce2_q;
            reg  [7:0]  sce3_q;
            reg  [7:0]  sce4_q;
            reg  [7:0]  lup1_q;
            reg  [7:0]  lup2_q;
            reg  [7:0]  ctrl_q;
            reg         scos_q;
            reg  [15:0] cnt_q;
            reg  [3:0]  phase_q;
            reg         det_q;
            reg  [7:0]  sum_q;
            reg  [7:0]  rd;
            wire        sel    = addrHit_q & (portIdx == p);
            wire        wrEn   = wrPend_q & sel;
            wire        rdClr  = rdPend_q & sel
                                 & (regIdx == `RIMC_IDX_STAT);
            wire        e1     = ctrl_q[`RIMC_CTRL_E1_BIT];
            wire [7:0]  wd     = hwdata[7:0];
            wire [31:0] chEn   = {sce4_q & {8{e1}}, sce3_q,
                                  sce2_q, sce1_q};
            wire [CHANNELS-1:0] chg =
                sigChange[p*CHANNELS +: CHANNELS];

            // ----------------------------------------------------------
            // per-channel change enables
            // ----------------------------------------------------------
            wire [CHANNELS-1:0] chHit;
            for (c = 0; c < CHANNELS; c = c + 1) begin : gChan
                assign chHit[c] = chg[c] & chEn[c];
            end
            wire        scosSet = |chHit;
            wire [7:0]  ev2 = latchedStatus2[p*8 +: 8];
            wire [7:0]  ev3 = latchedStatus3[p*8 +: 8];
            wire [7:0]  ev4 = latchedStatus4[p*8 +: 8]
                              | {4'h0, scos_q, 3'h0};
            wire [7:0]  ev5 = latchedStatus5[p*8 +: 8];
            wire [7:0]  ev7 = latchedStatus7[p*8 +: 8];

            // ----------------------------------------------------------
            // mask field decode: for mask2, mask3 and mask7 the mode decides which bits are live
            // ----------------------------------------------------------
            // E1 framing group, dead in T1
            wire        signalingAllOnesEn  = mask2_q[3];
            wire        signalingAllZerosEn = mask2_q[2];
            wire        crc4MultiframeEn    = mask2_q[1];
            wire        alignFrameEn        = mask2_q[0];
            wire [7:0]  m2 = {4'h0, signalingAllOnesEn, signalingAllZerosEn,
                              crc4MultiframeEn, alignFrameEn} & {8{e1}};

            // T1 line codes: clears in the top nibble
            wire [3:0]  t1ClearEn  = mask3_q[7:4];
            wire [3:0]  t1DetectEn = mask3_q[3:0];
            // E1 clock loss, link, distant alarm; 6 and 2 unused
            wire        clockLossClearEn       = mask3_q[7];
            wire        v52LinkClearEn         = mask3_q[5];
            wire        distantMfAlarmClearEn  = mask3_q[4];
            wire        clockLossDetectEn      = mask3_q[3];
            wire        v52LinkDetectEn        = mask3_q[1];
            wire        distantMfAlarmDetectEn = mask3_q[0];
            wire [7:0]  e1m3 = {clockLossClearEn, 1'b0, v52LinkClearEn,
                                distantMfAlarmClearEn, clockLossDetectEn,
                                1'b0, v52LinkDetectEn,
                                distantMfAlarmDetectEn};
            wire [7:0]  m3 = e1 ? e1m3 : {t1ClearEn, t1DetectEn};

            // elastic store, signaling change, timers
            wire        elasticFullEn     = mask4_q[7];
            wire        elasticEmptyEn    = mask4_q[6];
            wire        elasticSlipEn     = mask4_q[5];
            wire        mask4Bit3         = mask4_q[3];
            wire        oneSecondTickEn   = mask4_q[2];
            wire        timerEventEn      = mask4_q[1];
            wire        multiframeEventEn = mask4_q[0];
            wire [7:0]  m4 = {elasticFullEn, elasticEmptyEn, elasticSlipEn,
                              1'b0, mask4Bit3, oneSecondTickEn,
                              timerEventEn, multiframeEventEn};

            // HDLC receive FIFO group
            wire        fifoOverrunEn       = mask5_q[5];
            wire        hdlcOpeningByteEn   = mask5_q[4];
            wire        packetEndEn         = mask5_q[3];
            wire        packetStartEn       = mask5_q[2];
            wire        fifoHighWatermarkEn = mask5_q[1];
            wire        fifoNotEmptyEn      = mask5_q[0];
            wire [7:0]  m5 = {2'b00, fifoOverrunEn, hdlcOpeningByteEn,
                              packetEndEn, packetStartEn,
                              fifoHighWatermarkEn, fifoNotEmptyEn};

            // T1 code and data link group
            wire        remoteAlarmCiEn = mask7_q[5];
            wire        alarmSignalCiEn = mask7_q[4];
            wire        slcAlignmentEn  = mask7_q[3];
            wire        fdlFullEn       = mask7_q[2];
            wire        bocClearEn      = mask7_q[1];
            wire        bocDetectEn     = mask7_q[0];
            // E1 spare bits, already selected upstream
            wire        sa6CodewordEn    = mask7_q[1];
            wire        spareBitChangeEn = mask7_q[0];
            wire [7:0]  m7 = e1 ? {6'h00, sa6CodewordEn, spareBitChangeEn}
                                : {2'b00, remoteAlarmCiEn, alarmSignalCiEn,
                                   slcAlignmentEn, fdlFullEn,
                                   bocClearEn, bocDetectEn};

            // ----------------------------------------------------------
            // request is event AND enable per bit
            // ----------------------------------------------------------
            wire        rq2 = |(ev2 & m2);
            wire        rq3 = |(ev3 & m3);
            wire        rq4 = |(ev4 & m4);
            wire        rq5 = |(ev5 & m5);
            wire        rq7 = |(ev7 & m7);
            wire [7:0]  sumD = {1'b0, rq7, 1'b0, rq5, rq4, rq3, rq2, 1'b0};

            // ----------------------------------------------------------
            // loop-up pattern and status byte
            // ----------------------------------------------------------
            // status byte: sticky change, detector, port request
            wire [7:0]  statByte = {5'h00, |sum_q, det_q, scos_q};
            // pattern is lup1 then lup2, first bit at lup1 bit7
            wire [15:0] pat   = {lup1_q, lup2_q};
            wire [4:0]  len   = {1'b0, ctrl_q[`RIMC_CTRL_LEN_HI:
                                         `RIMC_CTRL_LEN_LO]} + 5'd1;
            wire        expB  = pat[4'd15 - phase_q];
            wire        rxB   = rxData[p];
            wire [3:0]  lastP = len[3:0] - 4'd1;
            wire        restart = wrEn & ((regIdx == `RIMC_IDX_LUP1)
                                  | (regIdx == `RIMC_IDX_LUP2)
                                  | (regIdx == `RIMC_IDX_CTRL));

            // register writes; fixed masks drop reserved bits of mask2, mask4, mask5 and mask7, mask3 stores all eight bits
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mask2_q <= `RIMC_RST_VAL;
                    mask3_q <= `RIMC_RST_VAL;
                    mask4_q <= `RIMC_RST_VAL;
                    mask5_q <= `RIMC_RST_VAL;
                    mask7_q <= `RIMC_RST_VAL;
                    sce1_q  <= `RIMC_RST_VAL;
                    sce2_q  <= `RIMC_RST_VAL;
                    sce3_q  <= `RIMC_RST_VAL;
                    sce4_q  <= `RIMC_RST_VAL;
                    lup1_q  <= `RIMC_RST_VAL;
                    lup2_q  <= `RIMC_RST_VAL;
                    ctrl_q  <= `RIMC_RST_VAL;
                end else if (wrEn) begin
                    case (regIdx)
                        `RIMC_IDX_MASK2: mask2_q <= wd & `RIMC_M2_BITS;
                        `RIMC_IDX_MASK3: mask3_q <= wd;
                        `RIMC_IDX_MASK4: mask4_q <= wd & `RIMC_M4_BITS;
                        `RIMC_IDX_MASK5: mask5_q <= wd & `RIMC_M5_BITS;
                        `RIMC_IDX_MASK7: mask7_q <= wd & `RIMC_M7_T1_BITS;
                        `RIMC_IDX_SCE1:  sce1_q  <= wd;
                        `RIMC_IDX_SCE2:  sce2_q  <= wd;
                        `RIMC_IDX_SCE3:  sce3_q  <= wd;
                        `RIMC_IDX_SCE4:  sce4_q  <= wd;
                        `RIMC_IDX_LUP1:  lup1_q  <= wd;
                        `RIMC_IDX_LUP2:  lup2_q  <= wd;
                        `RIMC_IDX_CTRL:  ctrl_q  <= wd;
                        default: ;
                    endcase
                end
            end

            // sticky change latch: a new change beats the read clear
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    scos_q <= 1'b0;
                end else if (scosSet) begin
                    scos_q <= 1'b1;
                end else if (rdClr) begin
                    scos_q <= 1'b0;
                end
            end

            // loop-up detector: counts bits in phase with the pattern,
            // a mismatch realigns on the first pattern bit
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q   <= 16'h0000;
                    phase_q <= 4'h0;
                    det_q   <= 1'b0;
                end else if (restart) begin
                    cnt_q   <= 16'h0000;
                    phase_q <= 4'h0;
                    det_q   <= 1'b0;
                end else if (rxDataValid[p]) begin
                    if (rxB == expB) begin
                        phase_q <= (phase_q == lastP) ? 4'h0
                                                      : phase_q + 4'h1;
                        if (cnt_q != LUP_INTEG)
                            cnt_q <= cnt_q + 16'h0001;
                        det_q <= (cnt_q + 16'h0001 >= LUP_INTEG);
                    end else begin
                        phase_q <= (rxB == pat[15] && lastP != 4'h0)
                                   ? 4'h1 : 4'h0;
                        cnt_q   <= {15'h0000, rxB == pat[15]};
                        det_q   <= 1'b0;
                    end
                end
            end

            // masked bits never reach the summary
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sum_q <= 8'h00;
                end else begin
                    sum_q <= sumD;
                end
            end

            // read mux for this port
            always @* begin
                rd = 8'h00;
                case (regIdx)
                    `RIMC_IDX_MASK2: rd = mask2_q;
                    `RIMC_IDX_MASK3: rd = mask3_q;
                    `RIMC_IDX_MASK4: rd = mask4_q;
                    `RIMC_IDX_MASK5: rd = mask5_q;
                    `RIMC_IDX_MASK7: rd = mask7_q;
                    `RIMC_IDX_SCE1:  rd = sce1_q;
                    `RIMC_IDX_SCE2:  rd = sce2_q;
                    `RIMC_IDX_SCE3:  rd = sce3_q;
                    `RIMC_IDX_SCE4:  rd = sce4_q;
                    `RIMC_IDX_LUP1:  rd = lup1_q;
                    `RIMC_IDX_LUP2:  rd = lup2_q;
                    `RIMC_IDX_CTRL:  rd = ctrl_q;
                    `RIMC_IDX_STAT:  rd = statByte;
                    default:         rd = 8'h00;
                endcase
            end

            assign portRd[p*8 +: 8]       = rd;
            assign portReq[p]             = |sumD;
            assign loopUpDet[p]           = det_q;
            assign rxIntSummary[p*8 +: 8] = sum_q;
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt pin: any request of any port pulls it low
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interruptOutN <= 1'b1;
        end else begin
            interruptOutN <= ~|portReq;
        end
    end

endmodule

`default_nettype wire

// ===== verification/rimc_checker.sv
`timescale 1ns/10ps
`default_nettype none
// port-level relations of the mask bank, port 0 for the byte checks
module rimc_checker #(
    parameter PORTS = 8
) (
    input wire                 clock,
    input wire                 rst_n,
    input wire                 hsel,
    input wire [31:0]          haddr,
    input wire [1:0]           htrans,
    input wire                 hwrite,
    input wire                 hready,
    input wire                 hreadyout,
    input wire                 hresp,
    input wire [PORTS*8-1:0]   latchedStatus2,
    input wire [PORTS*8-1:0]   latchedStatus5,
    input wire [PORTS-1:0]     rxDataValid,
    input wire [PORTS-1:0]     loopUpDet,
    input wire [PORTS*8-1:0]   rxIntSummary,
    input wire                 interruptOutN
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // taken bus requests; lup1 of port 0 sits at byte 2b0
    wire rdTaken = hsel && hready && htrans[1] && !hwrite;
    wire lupWr = hsel && hready && htrans[1] && hwrite && haddr == 32'h2b0;
    // summaries, pin, bus answer and loop-up detector
    property p_int_or; interruptOutN == !(|rxIntSummary); endproperty
    a_int_or: assert property (p_int_or)
        else $error("pin disagrees with summaries");
    property p_sum_res; (rxIntSummary[7:0] & 8'ha1) == 8'h00; endproperty
    a_sum_res: assert property (p_sum_res)
        else $error("unused summary bit set");
    property p_sum2; rxIntSummary[1] |-> $past(|latchedStatus2[7:0]); endproperty
    a_sum2: assert property (p_sum2)
        else $error("framing summary without event");
    property p_sum5; rxIntSummary[4] |-> $past(|latchedStatus5[7:0]); endproperty
    a_sum5: assert property (p_sum5)
        else $error("hdlc summary without event");
    property p_rd_wait; rdTaken |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay)
        else $error("error response seen");
    property p_lup_rise; $rose(loopUpDet[0]) |-> $past(rxDataValid[0]); endproperty
    a_lup_rise: assert property (p_lup_rise)
        else $error("detect rose without bit strobe");
    property p_lup_clr; lupWr |-> ##2 !loopUpDet[0]; endproperty
    a_lup_clr: assert property (p_lup_clr)
        else $error("pattern write did not restart");
endmodule
bind rimc_rx_int_mask rimc_checker #(.PORTS(PORTS)) chk (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp),
    .latchedStatus2(latchedStatus2), .latchedStatus5(latchedStatus5),
    .rxDataValid(rxDataValid), .loopUpDet(loopUpDet),
    .rxIntSummary(rxIntSummary), .interruptOutN(interruptOutN)
);
`default_nettype wire

// ===== verification/test_rx_interrupt_mask_and_loopup_code.sv
`timescale 1ns/10ps
`default_nettype none
module test_rx_interrupt_mask_and_loopup_code;
    logic         clock, rst_n, hsel, hwrite;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, rd;
    logic [63:0]  latchedStatus2, latchedStatus3, latchedStatus4;
    logic [63:0]  latchedStatus5, latchedStatus7;
    logic [255:0] sigChange;
    logic [7:0]   rxData, rxDataValid, m;
    wire  [31:0]  hrdata;
    wire          hreadyout, hresp, interruptOutN, hready;
    wire  [7:0]   loopUpDet;
    wire  [63:0]  rxIntSummary;
    int           mismatches, comparisons;
    logic [7:0]   idxs [0:10] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha6, 8'ha8,
                                  8'ha9, 8'haa, 8'hab, 8'hac, 8'had};
    logic [7:0]   bits [0:10] = '{8'h0f, 8'hff, 8'hef, 8'h3f, 8'h3f, 8'hff,
                                  8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    // short integration keeps the detector runs brief
    rimc_rx_int_mask #(.LUP_INTEG(16'd4)) dut (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .latchedStatus2(latchedStatus2),
        .latchedStatus3(latchedStatus3), .latchedStatus4(latchedStatus4),
        .latchedStatus5(latchedStatus5), .latchedStatus7(latchedStatus7),
        .sigChange(sigChange), .rxData(rxData), .rxDataValid(rxDataValid),
        .loopUpDet(loopUpDet), .rxIntSummary(rxIntSummary),
        .interruptOutN(interruptOutN)
    );
    // clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done;
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait for hready sampled high
    task automatic waitReady;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t bus hang", $time);
            test_done;
        end
    endtask
    // one single-word transfer, address phase then data phase
    task automatic bus(input int p, input [7:0] i, input w, input [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= (p * 32'h200 + i) << 2;
        waitReady;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        waitReady;
        rd = hrdata;
    endtask
    // read and compare
    task automatic rdChk(input int p, input [7:0] i, input [7:0] e);
        bus(p, i, 1'b0, 8'h00);
        check(rd, {24'h0, e});
    endtask
    // port 0 events, summary seen two edges on
    task automatic evt(input [7:0] s2, s3, s5, s7, e);
        latchedStatus2[7:0] <= s2;
        latchedStatus3[7:0] <= s3;
        latchedStatus5[7:0] <= s5;
        latchedStatus7[7:0] <= s7;
        repeat (2) @(posedge clock);
        check(rxIntSummary[7:0], e);
    endtask
    // reset values, writable bits, unmapped place
    task automatic regTable;
        for (int k = 0; k < 11; k++) begin
            rdChk(0, idxs[k], 8'h00);
            bus(0, idxs[k], 1'b1, 8'hff);
            rdChk(0, idxs[k], bits[k]);
        end
        rdChk(0, 8'hb0, 8'h00);
    endtask
    // private copy at port 7, each mask4 bit gating its event
    task automatic portEvents;
        bus(7, 8'ha3, 1'b1, 8'h28);
        rdChk(7, 8'ha3, 8'h28);
        rdChk(0, 8'ha3, 8'hef);
        m = 8'h28;
        for (int b = 0; b < 8; b++) begin
            latchedStatus4 <= 64'h1 << (56 + b);
            repeat (2) @(posedge clock);
            check(rxIntSummary[63:56], {m[b], 3'h0});
            check(interruptOutN, !m[b]);
        end
        latchedStatus4 <= '0;
    endtask
    // E1 readings of mask2, mask3, mask5 and mask7
    task automatic e1Masks;
        bus(0, 8'hf0, 1'b1, 8'h01);
        evt(8'h08, 8'h00, 8'h00, 8'h00, 8'h02);
        evt(8'h10, 8'h00, 8'h00, 8'h00, 8'h00);
        evt(8'h00, 8'h04, 8'h00, 8'h00, 8'h00);
        evt(8'h00, 8'h20, 8'h00, 8'h00, 8'h04);
        evt(8'h00, 8'h00, 8'h20, 8'h00, 8'h10);
        evt(8'h00, 8'h00, 8'h00, 8'h02, 8'h40);
        evt(8'h00, 8'h00, 8'h00, 8'h01, 8'h40);
        evt(8'h00, 8'h00, 8'h00, 8'h04, 8'h00);
        evt(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    endtask
    // one channel change, then the sticky latch read and cleared
    task automatic pulse(input int c, input e);
        sigChange[c] <= 1'b1;
        @(posedge clock);
        sigChange <= '0;
        repeat (3) @(posedge clock);
        check(rxIntSummary[3], e);
        bus(0, 8'hf1, 1'b0, 8'h00);
        check(rd[0], e);
    endtask
    // channel enables, first and last channel
    task automatic sigChg;
        bus(0, 8'ha8, 1'b1, 8'h01);
        bus(0, 8'ha9, 1'b1, 8'h00);
        bus(0, 8'haa, 1'b1, 8'h00);
        bus(0, 8'hab, 1'b1, 8'h80);
        bus(0, 8'ha3, 1'b1, 8'h08);
        pulse(0, 1'b1);
        pulse(1, 1'b0);
        pulse(31, 1'b1);
    endtask
    // serial bits on port 0, msb first
    task automatic sendBits(input [7:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            rxData[0]      <= v[k];
            rxDataValid[0] <= 1'b1;
            @(posedge clock);
            rxDataValid[0] <= 1'b0;
            @(posedge clock);
        end
    endtask
    // three-bit code 110, noisy low bits and second register
    task automatic loopUp;
        bus(0, 8'hf0, 1'b1, 8'h20);
        evt(8'h08, 8'h44, 8'h00, 8'h3c, 8'h44);
        evt(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        bus(0, 8'hac, 1'b1, 8'hc5);
        bus(0, 8'had, 1'b1, 8'h5a);
        sendBits(8'h06, 3);
        check(loopUpDet[0], 1'b0);
        sendBits(8'h01, 1);
        check(loopUpDet[0], 1'b1);
        bus(0, 8'hac, 1'b1, 8'hc5);
        @(posedge clock);
        check(loopUpDet[0], 1'b0);
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        hsize = 3'b010;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {latchedStatus2, latchedStatus3, latchedStatus4} = '0;
        {latchedStatus5, latchedStatus7, sigChange} = '0;
        {rxData, rxDataValid, mismatches, comparisons} = '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        regTable;
        portEvents;
        e1Masks;
        sigChg;
        loopUp;
        test_done;
    end
endmodule
`default_nettype wire
